// file: verilog/bmc_defs.svh
// Constants of the bus-master command and transmit auto-poll configuration block.
// Assumes a 100 MHz bus clock; included by bare name from the design files.
`ifndef BMC_DEFS_SVH
`define BMC_DEFS_SVH

// Register map and reset image
`define BMC_ACCESS_CTRL_OFF  8'h00
`define BMC_ACCESS_CTRL_RST  32'h0000_1000
`define BMC_PBL_RST          6'h10

// Field positions inside the access control register
`define BMC_MWI_BIT          24
`define BMC_MRL_BIT          23
`define BMC_MRM_BIT          21
`define BMC_POLL_MSB         18
`define BMC_POLL_LSB         17
`define BMC_CAL_MSB          15
`define BMC_CAL_LSB          14
`define BMC_PBL_MSB          13
`define BMC_PBL_LSB          8
`define BMC_BLE_BIT          7
`define BMC_DSL_MSB          6
`define BMC_DSL_LSB          2
`define BMC_BAR_BIT          1
`define BMC_SWR_BIT          0

// Alignment encodings turned into doubleword-offset masks
`define BMC_CAL_RSVD         2'h0
`define BMC_CAL_8DW_MASK     5'h07
`define BMC_CAL_16DW_MASK    5'h0F
`define BMC_CAL_32DW_MASK    5'h1F

// Bus command codes
`define BMC_CMD_MR           4'h6
`define BMC_CMD_MRL          4'hE
`define BMC_CMD_MRM          4'hC
`define BMC_CMD_MW           4'h7
`define BMC_CMD_MWI          4'hF

// Poll intervals and their cycle counts
`define BMC_CLK_PERIOD_NS    10
`define BMC_POLL1_US         200
`define BMC_POLL2_US         800
`define BMC_POLL3_US         1600
`define BMC_POLL1_CYC        (`BMC_POLL1_US * 1000 / `BMC_CLK_PERIOD_NS)
`define BMC_POLL2_CYC        (`BMC_POLL2_US * 1000 / `BMC_CLK_PERIOD_NS)
`define BMC_POLL3_CYC        (`BMC_POLL3_US * 1000 / `BMC_CLK_PERIOD_NS)
`define BMC_POLL_OFF         2'h0
`define BMC_POLL_CNT_W       18

`endif

// file: verilog/bmc_pkg.sv
// Types shared by the bus-master command block and its poll timer.
// Assumes bmc_defs.svh is on the include path.
`include "bmc_defs.svh"

package bmc_pkg;

  // Descriptor fetch sequencer states
  typedef enum logic {
    FS_IDLE,
    FS_FETCH
  } fetch_state_t;

  // Whole state of the control module
  typedef struct packed {
    logic         mwi_en;
    logic         mrl_en;
    logic         mrm_en;
    logic [1:0]   poll_sel;
    logic [1:0]   cal;
    logic [5:0]   pbl;
    logic         ble;
    logic [4:0]   dsl;
    logic         bar;
    logic         swr;
    logic [31:0]  rdata;
    logic         cmd_valid;
    logic [3:0]   cmd_code;
    fetch_state_t fs;
    logic         fetch_req;
    logic         tx_start;
  } ctl_state_t;

  // Whole state of the poll timer
  typedef struct packed {
    logic [`BMC_POLL_CNT_W-1:0] cnt;
    logic                       susp_prev;
    logic                       tick;
  } tmr_state_t;

endpackage

// file: verilog/poll_if.sv
// Carrier between the control module and its transmit auto-poll timer.
// Assumes both ends run on the same bus clock.
`timescale 1ns/10ps
`default_nettype none

interface poll_if;
  logic       susp;  // Transmitter is in the suspended state
  logic [1:0] sel;   // Auto-poll interval select
  logic       tick;  // One-cycle poll event

  modport timer (input susp, input sel, output tick);
  modport ctrl  (output susp, output sel, input tick);
endinterface

`default_nettype wire

// file: verilog/tx_poll_timer.sv
// Transmit auto-poll timer: emits one tick per interval while suspended.
// Assumes the suspend level and interval select are synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
`include "bmc_defs.svh"

module tx_poll_timer #(
  parameter logic [`BMC_POLL_CNT_W-1:0] POLL1_CYC = `BMC_POLL_CNT_W'(`BMC_POLL1_CYC),
  parameter logic [`BMC_POLL_CNT_W-1:0] POLL2_CYC = `BMC_POLL_CNT_W'(`BMC_POLL2_CYC),
  parameter logic [`BMC_POLL_CNT_W-1:0] POLL3_CYC = `BMC_POLL_CNT_W'(`BMC_POLL3_CYC)
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  poll_if.timer     p
);
  import bmc_pkg::*;

  tmr_state_t                 s_q;
  tmr_state_t                 s_d;
  logic [`BMC_POLL_CNT_W-1:0] last_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Interval select; a zero select gives a terminal count of zero and is kept from ticking by the clear below
  always_comb begin
    case (p.sel)
      2'h1:    last_cnt = POLL1_CYC - 1'b1;
      2'h2:    last_cnt = POLL2_CYC - 1'b1;
      2'h3:    last_cnt = POLL3_CYC - 1'b1;
      default: last_cnt = '0;
    endcase
  end

  // Counter restarts on entry to suspend and is held at zero outside it
  always_comb begin
    s_d           = s_q;
    s_d.susp_prev = p.susp;
    s_d.tick      = 1'b0;
    if (!p.susp || !s_q.susp_prev || p.sel == `BMC_POLL_OFF) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == last_cnt) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign p.tick = s_q.tick;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the timer
  AST_POLL_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
    p.sel == `BMC_POLL_OFF |=> !s_q.tick)
    else $error("poll tick while auto-poll is disabled");
  AST_SUSP_STOP: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !p.susp |=> s_q.cnt == '0 && !s_q.tick)
    else $error("poll timer ran outside suspend");
  AST_SUSP_RESTART: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(p.susp) |=> s_q.cnt == '0)
    else $error("poll interval did not restart on suspend entry");
  AST_TICK_PERIOD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_q.tick && p.sel != `BMC_POLL_OFF |-> s_q.cnt == '0 ##1 s_q.cnt <= 1)
    else $error("poll counter did not restart after tick");
  COV_TICK: cover property (@(posedge ref_clk) disable iff (sys_rst) s_q.tick);

endmodule

`default_nettype wire

// file: verilog/bus_master_cmd_cfg.sv
// Bus access control register and bus-master command selection with auto-poll.
// Assumes requests, register strobes and descriptor answers are synchronous to ref_clk.
//
// Notes on behaviour
// - With write-invalidate disabled every write uses the plain memory write command.
// - With write-invalidate enabled an aligned write of at least a full line uses it.
// - With read-line enabled a read reaching a line boundary uses read line unless read multiple applies, else plain read.
// - With read-multiple enabled an aligned full-line read uses it, misaligned ones do not.
// - The auto-poll field selects off, 200 us, 800 us or 1600 us poll intervals.
// - The register sits at offset zero, resets to 0x00001000 and reads zero in reserved bits.
// - The alignment field gives the line as 8, 16 or 32 doublewords; 00 means none.
// - Each poll event with no fetch outstanding fetches the transmit descriptor and starts transmit if the device owns it.
`timescale 1ns/10ps
`default_nettype none
`include "bmc_defs.svh"

module bus_master_cmd_cfg #(
  parameter int unsigned POLL1_CYC = `BMC_POLL1_CYC,
  parameter int unsigned POLL2_CYC = `BMC_POLL2_CYC,
  parameter int unsigned POLL3_CYC = `BMC_POLL3_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        csr_wr_en,
  input  wire logic        csr_rd_en,
  input  wire logic [7:0]  csr_addr,
  input  wire logic [31:0] csr_wdata,
  output var  logic [31:0] csr_rdata,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [31:0] req_addr,
  input  wire logic [7:0]  req_len_dw,
  output var  logic        cmd_valid,
  output var  logic [3:0]  cmd_code,
  input  wire logic        tx_suspended,
  output var  logic        desc_fetch_req,
  input  wire logic        desc_fetch_done,
  input  wire logic        desc_owned,
  output var  logic        tx_start,
  output var  logic        soft_reset
);
  import bmc_pkg::*;

  ctl_state_t s_q;
  ctl_state_t s_d;
  logic [4:0] line_mask;
  logic       line_ok;
  logic [4:0] line_off;
  logic [5:0] line_len;
  logic       aligned;
  logic       full_line;
  logic       reach_bound;
  logic       acc_sel;
  poll_if     pif ();

  ////////////////////////////////////////////////////////////////////////////
  // Line geometry of the current request from the alignment field
  always_comb begin
    case (s_q.cal)
      2'h1:    line_mask = `BMC_CAL_8DW_MASK;
      2'h2:    line_mask = `BMC_CAL_16DW_MASK;
      2'h3:    line_mask = `BMC_CAL_32DW_MASK;
      default: line_mask = 5'h00;
    endcase
  end

  // Reserved alignment disables every cache-line command
  assign line_ok     = s_q.cal != `BMC_CAL_RSVD;
  assign line_off    = req_addr[6:2] & line_mask;
  assign line_len    = {1'b0, line_mask} + 6'h01;
  assign aligned     = line_off == 5'h00;
  assign full_line   = req_len_dw >= {2'b00, line_len};
  assign reach_bound = ({4'h0, line_off} + {1'b0, req_len_dw}) >= {3'b000, line_len};
  assign acc_sel     = csr_addr == `BMC_ACCESS_CTRL_OFF;

  ////////////////////////////////////////////////////////////////////////////
  // Register image; reserved bits are tied to zero
  function automatic logic [31:0] reg_image(input ctl_state_t s);
    reg_image = {7'h00, s.mwi_en, s.mrl_en, 1'b0, s.mrm_en, 2'b00, s.poll_sel,
                 1'b0, s.cal, s.pbl, s.ble, s.dsl, s.bar, s.swr};
  endfunction

  // Next state: register access, command choice and descriptor fetch
  always_comb begin
    s_d           = s_q;
    s_d.swr       = 1'b0; // Self-clearing pulse into the engine reset
    s_d.cmd_valid = req_valid;
    s_d.tx_start  = 1'b0;
    s_d.rdata     = (csr_rd_en && acc_sel) ? reg_image(s_q) : 32'h0000_0000;
    // Field changes assume the engines are idle; nothing here guards them
    if (csr_wr_en && acc_sel) begin
      s_d.mwi_en   = csr_wdata[`BMC_MWI_BIT];
      s_d.mrl_en   = csr_wdata[`BMC_MRL_BIT];
      s_d.mrm_en   = csr_wdata[`BMC_MRM_BIT];
      s_d.poll_sel = csr_wdata[`BMC_POLL_MSB:`BMC_POLL_LSB];
      s_d.cal      = csr_wdata[`BMC_CAL_MSB:`BMC_CAL_LSB];
      s_d.pbl      = csr_wdata[`BMC_PBL_MSB:`BMC_PBL_LSB];
      s_d.ble      = csr_wdata[`BMC_BLE_BIT];
      s_d.dsl      = csr_wdata[`BMC_DSL_MSB:`BMC_DSL_LSB];
      s_d.bar      = csr_wdata[`BMC_BAR_BIT];
      s_d.swr      = csr_wdata[`BMC_SWR_BIT];
    end
    // Command choice; multiple wins over line when both apply
    if (req_valid) begin
      if (req_write) begin
        if (s_q.mwi_en && line_ok && aligned && full_line) begin
          s_d.cmd_code = `BMC_CMD_MWI;
        end else begin
          s_d.cmd_code = `BMC_CMD_MW;
        end
      end else if (s_q.mrm_en && line_ok && aligned && full_line) begin
        s_d.cmd_code = `BMC_CMD_MRM;
      end else if (s_q.mrl_en && line_ok && reach_bound) begin
        s_d.cmd_code = `BMC_CMD_MRL;
      end else begin
        s_d.cmd_code = `BMC_CMD_MR;
      end
    end
    // Poll ticks during an outstanding fetch are dropped, not queued
    case (s_q.fs)
      FS_IDLE: begin
        if (pif.tick) begin
          s_d.fs        = FS_FETCH;
          s_d.fetch_req = 1'b1;
        end
      end
      FS_FETCH: begin
        if (desc_fetch_done) begin
          s_d.fs        = FS_IDLE;
          s_d.fetch_req = 1'b0;
          s_d.tx_start  = desc_owned;
        end
      end
      default: begin
        s_d.fs        = FS_IDLE;
        s_d.fetch_req = 1'b0;
      end
    endcase
  end

  // State register; only the burst length field is non-zero after reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q     <= '0;
      s_q.pbl <= `BMC_PBL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auto-poll timer on the bus clock
  assign pif.susp = tx_suspended;
  assign pif.sel  = s_q.poll_sel;

  tx_poll_timer #(
    .POLL1_CYC (`BMC_POLL_CNT_W'(POLL1_CYC)),
    .POLL2_CYC (`BMC_POLL_CNT_W'(POLL2_CYC)),
    .POLL3_CYC (`BMC_POLL_CNT_W'(POLL3_CYC))
  ) u_timer (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .p       (pif.timer)
  );

  assign csr_rdata      = s_q.rdata;
  assign cmd_valid      = s_q.cmd_valid;
  assign cmd_code       = s_q.cmd_code;
  assign desc_fetch_req = s_q.fetch_req;
  assign tx_start       = s_q.tx_start;
  assign soft_reset     = s_q.swr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on command choice, register and fetch sequence
  AST_NO_MWI: assert property (@(posedge ref_clk) disable iff (sys_rst)
    req_valid && req_write && !s_q.mwi_en |=> cmd_valid && cmd_code == `BMC_CMD_MW)
    else $error("write used a non-plain command with invalidate disabled");
  AST_MWI_FULL: assert property (@(posedge ref_clk) disable iff (sys_rst)
    req_valid && req_write && s_q.mwi_en && line_ok && aligned && full_line
    |=> cmd_code == `BMC_CMD_MWI)
    else $error("full-line write did not use write and invalidate");
  AST_MRL_BOUND: assert property (@(posedge ref_clk) disable iff (sys_rst)
    req_valid && !req_write && s_q.mrl_en && line_ok && reach_bound
    && !(s_q.mrm_en && aligned && full_line) |=> cmd_code == `BMC_CMD_MRL)
    else $error("read reaching a line boundary did not use read line");
  AST_MR_PLAIN: assert property (@(posedge ref_clk) disable iff (sys_rst)
    req_valid && !req_write && !s_q.mrl_en && !s_q.mrm_en |=> cmd_code == `BMC_CMD_MR)
    else $error("read used a line command while disabled");
  AST_MRM_FULL: assert property (@(posedge ref_clk) disable iff (sys_rst)
    req_valid && !req_write && s_q.mrm_en && line_ok && aligned && full_line
    |=> cmd_code == `BMC_CMD_MRM)
    else $error("aligned full-line read did not use read multiple");
  AST_MRM_MISALIGN: assert property (@(posedge ref_clk) disable iff (sys_rst)
    req_valid && !req_write && !aligned |=> cmd_code != `BMC_CMD_MRM)
    else $error("misaligned read used read multiple");
  AST_CAL_RSVD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    req_valid && s_q.cal == `BMC_CAL_RSVD
    |=> cmd_code == `BMC_CMD_MW || cmd_code == `BMC_CMD_MR)
    else $error("cache-line command with reserved alignment");
  AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
    csr_rd_en && acc_sel |=> csr_rdata[31:25] == 7'h00 && !csr_rdata[22]
    && csr_rdata[20:19] == 2'b00 && !csr_rdata[16])
    else $error("reserved bits read non-zero");
  AST_FETCH_START: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pif.tick && s_q.fs == FS_IDLE |=> desc_fetch_req)
    else $error("poll event did not request a descriptor fetch");
  AST_TX_START: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_q.fs == FS_FETCH && desc_fetch_done |=> tx_start == $past(desc_owned) && !desc_fetch_req)
    else $error("transmit start does not follow descriptor ownership");

  COV_MWI: cover property (@(posedge ref_clk) disable iff (sys_rst)
    cmd_valid && cmd_code == `BMC_CMD_MWI);
  COV_MRM: cover property (@(posedge ref_clk) disable iff (sys_rst)
    cmd_valid && cmd_code == `BMC_CMD_MRM);
  COV_MRL: cover property (@(posedge ref_clk) disable iff (sys_rst)
    cmd_valid && cmd_code == `BMC_CMD_MRL);
  COV_TX_START: cover property (@(posedge ref_clk) disable iff (sys_rst) tx_start);

endmodule

`default_nettype wire

// file: verif/desc_mem_model.sv
// Behavioural host memory that answers transmit descriptor fetches.
// Assumes fetch requests are levels on ref_clk and held until answered.
`timescale 1ns/10ps
`default_nettype none

module desc_mem_model (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       fetch_req,
  input  wire logic       own_bit,
  input  wire logic [3:0] dly,
  output var  logic       fetch_done,
  output var  logic       fetch_owned
);
  logic [3:0] cnt_q;
  logic       drain_q;

  // Answer after dly cycles; the ownership line toggles when not qualified
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
      drain_q <= 1'b0;
      fetch_done <= 1'b0;
      fetch_owned <= 1'b0;
    end else begin
      fetch_done <= 1'b0;
      fetch_owned <= ~fetch_owned;
      if (fetch_done) begin
        drain_q <= 1'b1;
      end else if (drain_q) begin
        drain_q <= fetch_req; // Serve nothing until the old request is dropped
      end else if (fetch_req && cnt_q >= dly) begin
        fetch_done <= 1'b1;
        fetch_owned <= own_bit;
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= fetch_req ? cnt_q + 4'h1 : 4'h0;
      end
    end
  end
endmodule

`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the bus-master command and auto-poll block.
// Assumes bmc_defs.svh on the include path and a 100 MHz ref_clk.
`timescale 1ns/10ps
`default_nettype none
`include "bmc_defs.svh"

module tb_top;
  localparam int P1 = 20; // Short poll counts keep the run brief
  localparam int P2 = 40;
  localparam int P3 = 80;
  logic        ref_clk;
  logic        sys_rst;
  logic        csr_wr_en;
  logic        csr_rd_en;
  logic [7:0]  csr_addr;
  logic [31:0] csr_wdata;
  logic [31:0] csr_rdata;
  logic        req_valid;
  logic        req_write;
  logic [31:0] req_addr;
  logic [7:0]  req_len_dw;
  logic        cmd_valid;
  logic [3:0]  cmd_code;
  logic        tx_suspended;
  logic        desc_fetch_req;
  logic        desc_fetch_done;
  logic        desc_owned;
  logic        tx_start;
  logic        soft_reset;
  logic        own_bit;
  logic [3:0]  fetch_dly;
  logic        req_prev;
  logic [31:0] cfg;
  logic [3:0]  exp_q[$];
  int          fr[$];
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          starts = 0;
  int          resets = 0;
  int          seed;

  bus_master_cmd_cfg #(.POLL1_CYC(P1), .POLL2_CYC(P2), .POLL3_CYC(P3)) u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .csr_wr_en(csr_wr_en), .csr_rd_en(csr_rd_en),
    .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_len_dw(req_len_dw), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .tx_suspended(tx_suspended), .desc_fetch_req(desc_fetch_req),
    .desc_fetch_done(desc_fetch_done), .desc_owned(desc_owned), .tx_start(tx_start),
    .soft_reset(soft_reset));

  desc_mem_model u_mem (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .fetch_req(desc_fetch_req), .own_bit(own_bit),
    .dly(fetch_dly), .fetch_done(desc_fetch_done), .fetch_owned(desc_owned));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference command choice, worked out with integers
  function automatic logic [3:0] exp_cmd(logic [31:0] c, logic w, logic [31:0] a, int len);
    int line;
    int off;
    line = (c[15:14] == 2'h0) ? 0 : (4 << c[15:14]);
    off = (line == 0) ? 0 : (int'(a[6:2]) & (line - 1));
    if (w)
      return (c[24] && line != 0 && off == 0 && len >= line) ? `BMC_CMD_MWI : `BMC_CMD_MW;
    if (c[21] && line != 0 && off == 0 && len >= line)
      return `BMC_CMD_MRM;
    return (c[23] && line != 0 && off + len >= line) ? `BMC_CMD_MRL : `BMC_CMD_MR;
  endfunction

  task automatic mismatch(string what);
    num_errors++;
    $display("unexpected at %0t: %s", $time, what);
  endtask
  task automatic check_reg(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) mismatch($sformatf("register read %h, wanted %h", got, exp));
  endtask
  task automatic check_cmd(logic [3:0] got, logic [3:0] exp);
    cmp_count++;
    if (got !== exp) mismatch($sformatf("command %h, wanted %h", got, exp));
  endtask
  task automatic check_cnt(int got, int exp);
    cmp_count++;
    if (got != exp) mismatch($sformatf("count %0d, wanted %0d", got, exp));
  endtask
  task automatic complete_run;
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watch fetch starts, transmit starts and every issued command
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    req_prev <= desc_fetch_req;
    if (desc_fetch_req === 1'b1 && req_prev !== 1'b1)
      fr.push_back(cyc);
    if (tx_start === 1'b1)
      starts++;
    if (soft_reset === 1'b1)
      resets++;
    if (cmd_valid === 1'b1) begin
      if (exp_q.size() == 0)
        mismatch("command without request");
      else
        check_cmd(cmd_code, exp_q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register strobes and requests, driven on the falling edge
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(negedge ref_clk);
    csr_wr_en = 1'b1;
    csr_addr = a;
    csr_wdata = d;
    @(negedge ref_clk);
    csr_wr_en = 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, logic [31:0] exp);
    @(negedge ref_clk);
    csr_rd_en = 1'b1;
    csr_addr = a;
    @(negedge ref_clk);
    csr_rd_en = 1'b0;
    check_reg(csr_rdata, exp);
  endtask
  // Only called while the transmitter is idle and no request is in flight
  task automatic set_cfg(logic [31:0] d);
    cfg = d;
    wr_reg(8'h00, d);
  endtask
  task automatic send_req(logic w, logic [31:0] a, logic [7:0] len);
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_len_dw = len;
    exp_q.push_back(exp_cmd(cfg, w, a, int'(len)));
  endtask

  // A short suspend first proves the interval restarts on each entry
  task automatic run_poll(logic [1:0] sel, int n);
    int t0;
    int s0;
    int k;
    set_cfg(32'h0000_5000 | (32'(sel) << 17));
    own_bit = 1'($random(seed));
    fetch_dly = 4'($random(seed) & 3) + 4'h1;
    @(negedge ref_clk);
    tx_suspended = 1'b1;
    repeat (n - 5) @(negedge ref_clk);
    tx_suspended = 1'b0;
    @(negedge ref_clk);
    fr.delete();
    s0 = starts;
    tx_suspended = 1'b1;
    t0 = cyc;
    k = (sel == 2'h0) ? 0 : 3;
    repeat (3 * n + 14) @(negedge ref_clk);
    check_cnt(fr.size(), k);
    check_cnt(starts - s0, own_bit ? k : 0);
    if (k == 3) begin
      check_cnt(fr[1] - fr[0], n);
      check_cnt(fr[2] - fr[1], n);
      check_cnt(int'(fr[0] - t0 >= n + 1 && fr[0] - t0 <= n + 4), 1);
    end
    tx_suspended = 1'b0;
    k = fr.size();
    repeat (2 * n + 10) @(negedge ref_clk);
    check_cnt(fr.size(), k);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] a;
    logic [7:0]  ln;
    seed = 32'hb9eb_9d30;
    sys_rst = 1'b1;
    csr_wr_en = 1'b0;
    csr_rd_en = 1'b0;
    csr_addr = 8'h00;
    csr_wdata = 32'h0000_0000;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 32'h0000_0000;
    req_len_dw = 8'h00;
    tx_suspended = 1'b0;
    own_bit = 1'b0;
    fetch_dly = 4'h1;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    rd_reg(8'h00, `BMC_ACCESS_CTRL_RST);
    rd_reg(8'h04, 32'h0000_0000);
    wr_reg(8'h04, 32'hFFFF_FFFE);
    rd_reg(8'h00, `BMC_ACCESS_CTRL_RST);
    set_cfg(32'hFFFF_FFFE);
    rd_reg(8'h00, 32'h01A6_FFFE);
    // Software reset bit gives exactly one engine reset pulse and reads back cleared
    wr_reg(8'h00, 32'h0000_1001);
    @(negedge ref_clk);
    check_cnt(resets, 1);
    rd_reg(8'h00, `BMC_ACCESS_CTRL_RST);
    check_cnt(resets, 1);
    // Every alignment against every enable mix, requests back to back
    for (int i = 0; i < 32; i++) begin
      set_cfg(32'h0000_1000 | (32'(i & 3) << 14) | (32'(i & 4) << 22) | (32'(i & 8) << 20)
              | (32'(i & 16) << 17));
      for (int j = 0; j < 8; j++) begin
        a = $random(seed);
        ln = 8'($random(seed) & 63);
        if (j[0])
          a[6:2] = 5'h00;
        if (j == 1)
          ln = 8'(4 << (i & 3));
        if (j == 3)
          ln = 8'((4 << (i & 3)) - 1);
        send_req(j[1] ^ a[0], a, ln);
      end
      @(negedge ref_clk);
      req_valid = 1'b0;
      @(negedge ref_clk);
    end
    check_cnt(exp_q.size(), 0);
    run_poll(2'h0, P1);
    run_poll(2'h1, P1);
    run_poll(2'h2, P2);
    run_poll(2'h3, P3);
    complete_run();
  end

  // Cut a hang short well beyond the 1500 or so cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatch("watchdog expired");
    complete_run();
  end
endmodule

`default_nettype wire
